// file: rtl/issam_pkg.sv
// Purpose: constants and types for the two-wire slave status and address mask block
// Assumes: 16-bit register port, word index addressing
// Notes:   rule summary below
// Operation
// - the start flag is written on every start, repeated start or stop and is zero while disabled.
// - the start flag is one after a start or repeated start and zero after a stop.
// - the direction flag is one when the master reads and zero when the master writes.
// - the receive-full flag sets when a byte has landed in the receive holding register.
// - the receive-full flag is zero while no received byte waits in the holding register.
// - the transmit-full flag stays one while the 8-bit transmit holding byte is being sent.
// - the transmit-full flag clears once the byte has been sent and the holder is empty.
// - an address bit whose mask bit is one is a don't-care in address matching.
// - an address bit whose mask bit is zero must equal the own slave address bit.
// - mask bits 15 to 10 read zero; bits 9 to 0 are read/write and reset to zero.
package issam_pkg;

	localparam logic [3:0] ISSAM_ADR_STATUS = 4'h0;
	localparam logic [3:0] ISSAM_ADR_MASK   = 4'h1;
	localparam logic [3:0] ISSAM_ADR_CTRL   = 4'h2;
	localparam logic [3:0] ISSAM_ADR_OWN    = 4'h3;
	localparam logic [3:0] ISSAM_ADR_RXD    = 4'h4;
	localparam logic [3:0] ISSAM_ADR_TXD    = 4'h5;
	localparam logic [3:0] ISSAM_ADR_IST    = 4'h6;
	localparam logic [3:0] ISSAM_ADR_IMSK   = 4'h7;

	localparam int ISSAM_CTL_EN  = 0;
	localparam int ISSAM_CTL_TEN = 1;

	localparam int ISSAM_IB_START = 0;
	localparam int ISSAM_IB_STOP  = 1;
	localparam int ISSAM_IB_ADDR  = 2;
	localparam int ISSAM_IB_RX    = 3;
	localparam int ISSAM_IB_TX    = 4;
	localparam int ISSAM_NINT     = 5;

	localparam int               ISSAM_AW        = 10;
	localparam int               ISSAM_AW7       = 7;
	localparam logic [9:0]       ISSAM_MASK_RST  = 10'h000;
	localparam logic [4:0]       ISSAM_PREFIX10  = 5'h1e;
	localparam logic [3:0]       ISSAM_BYTE_BITS = 4'h8;

	typedef enum logic [2:0] {
		ISSAM_IDLE  = 3'b000,
		ISSAM_ADDR  = 3'b001,
		ISSAM_ADDR2 = 3'b010,
		ISSAM_RX    = 3'b011,
		ISSAM_ACK   = 3'b100,
		ISSAM_TX    = 3'b101,
		ISSAM_TACK  = 3'b110
	} issam_st_t;

	typedef struct packed {
		logic start_f;
		logic rw;
		logic receive_buffer_full_flag;
		logic transmit_buffer_full_flag;
	} issam_status_t;

	typedef struct packed {
		logic                  scl_m;
		logic                  scl_s;
		logic                  scl_d;
		logic                  sda_m;
		logic                  sda_s;
		logic                  sda_d;
		issam_st_t             st;
		issam_st_t             nx;
		logic [3:0]            bcnt;
		logic [7:0]            sh;
		logic [1:0]            hi;
		logic                  a10;
		logic                  sda_oe;
		logic                  sda_o;
		issam_status_t         stat;
		logic [7:0]            rx;
		logic [7:0]            tx;
		logic [9:0]            mask;
		logic [9:0]            own;
		logic                  en;
		logic                  ten;
		logic [ISSAM_NINT-1:0] ist;
		logic [ISSAM_NINT-1:0] imsk;
		logic                  irq;
		logic [15:0]           rdata;
	} issam_regs_t;

	localparam issam_regs_t ISSAM_RST = '0;

endpackage : issam_pkg

// file: rtl/issam_addr_match.sv
// Purpose: masked comparison of an incoming slave address with the own address
// Assumes: candidate already aligned to address bit positions
// Notes:   upper three bits ignored in 7-bit mode
`timescale 1ns/1ps
`default_nettype none
module issam_addr_match
	import issam_pkg::*;
(
	input  wire logic [9:0] cand,
	input  wire logic [9:0] own,
	input  wire logic [9:0] mask,
	input  wire logic       ten,
	output logic            hit
);
	logic [9:0] bit_ok;

	genvar i;
	generate
		for (i = 0; i < ISSAM_AW; i++) begin : g_bit
			if (i < ISSAM_AW7) begin : g_lo
				assign bit_ok[i] = mask[i] | (cand[i] == own[i]);
			end else begin : g_hi
				assign bit_ok[i] = mask[i] | (cand[i] == own[i]) | ~ten;
			end
		end
	endgenerate

	assign hit = &bit_ok;

endmodule : issam_addr_match
`default_nettype wire

// file: rtl/issam_top.sv
// Purpose: two-wire slave with status flags, address mask and interrupt
// Assumes: SCL and SDA arrive asynchronously and are sampled by CLK
// Notes:   no clock stretching; SDA is open drain, SDA_OE high pulls low
`timescale 1ns/1ps
`default_nettype none
module issam_top
	import issam_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic [3:0]  REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [15:0] REG_RDATA,
	input  wire logic        SCL_IN,
	input  wire logic        SDA_IN,
	output logic             SDA_OUT,
	output logic             SDA_OE,
	output logic             IRQ
);
	issam_regs_t           r;
	issam_regs_t           n;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  start_det;
	logic                  stop_det;
	logic [9:0]            cand;
	logic                  hit;
	logic                  is10;
	logic                  rx_done;
	logic                  tx_done;
	logic                  addr_ack;
	logic [ISSAM_NINT-1:0] ev;
	logic [ISSAM_NINT-1:0] w1c;

	issam_addr_match u_match (
		.cand (cand),
		.own  (r.own),
		.mask (r.mask),
		.ten  (r.ten),
		.hit  (hit)
	);

	always_comb begin
		n = r;
		// two-flop synchronisers, then one delayed copy for edge finding
		n.scl_m = SCL_IN;
		n.scl_s = r.scl_m;
		n.scl_d = r.scl_s;
		n.sda_m = SDA_IN;
		n.sda_s = r.sda_m;
		n.sda_d = r.sda_s;
		n.sda_o = 1'b0;
		scl_rise = r.scl_s & ~r.scl_d;
		scl_fall = ~r.scl_s & r.scl_d;
		start_det = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
		stop_det = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
		is10 = (r.sh[7:3] == ISSAM_PREFIX10);
		rx_done = 1'b0;
		tx_done = 1'b0;
		addr_ack = 1'b0;
		ev = '0;
		w1c = '0;

		// candidate address for the masked compare
		if (r.ten) begin
			if (r.st == ISSAM_ADDR2) begin
				cand = {r.hi, r.sh};
			end else begin
				cand = {r.sh[2:1], r.own[7:0]};
			end
		end else begin
			cand = {3'h0, r.sh[7:1]};
		end

		// register writes; clears come before link sets so a set wins
		if (REG_WR) begin
			case (REG_ADDR)
				ISSAM_ADR_MASK: begin
					n.mask = REG_WDATA[9:0];
				end
				ISSAM_ADR_CTRL: begin
					n.en = REG_WDATA[ISSAM_CTL_EN];
					n.ten = REG_WDATA[ISSAM_CTL_TEN];
				end
				ISSAM_ADR_OWN: begin
					n.own = REG_WDATA[9:0];
				end
				ISSAM_ADR_TXD: begin
					n.tx = REG_WDATA[7:0];
				end
				ISSAM_ADR_IST: begin
					w1c = REG_WDATA[ISSAM_NINT-1:0];
				end
				ISSAM_ADR_IMSK: begin
					n.imsk = REG_WDATA[ISSAM_NINT-1:0];
				end
				default: begin
				end
			endcase
		end
		if (REG_RD && REG_ADDR == ISSAM_ADR_RXD) begin
			n.stat.receive_buffer_full_flag = 1'b0;
		end

		// link side
		if (!n.en) begin
			n.st = ISSAM_IDLE;
			n.sda_oe = 1'b0;
			n.stat.start_f = 1'b0;
			n.a10 = 1'b0;
		end else if (start_det) begin
			n.st = ISSAM_ADDR;
			n.bcnt = '0;
			n.sda_oe = 1'b0;
			n.stat.start_f = 1'b1;
			ev[ISSAM_IB_START] = 1'b1;
		end else if (stop_det) begin
			n.st = ISSAM_IDLE;
			n.sda_oe = 1'b0;
			n.stat.start_f = 1'b0;
			n.a10 = 1'b0;
			ev[ISSAM_IB_STOP] = 1'b1;
		end else begin
			case (r.st)
				ISSAM_ADDR, ISSAM_ADDR2, ISSAM_RX: begin
					if (scl_rise && r.bcnt != ISSAM_BYTE_BITS) begin
						n.sh = {r.sh[6:0], r.sda_s};
						n.bcnt = r.bcnt + 4'h1;
					end else if (scl_fall && r.bcnt == ISSAM_BYTE_BITS) begin
						n.st = ISSAM_IDLE;
						if (r.st == ISSAM_ADDR) begin
							if (r.ten) begin
								if (is10 && hit && !r.sh[0]) begin
									addr_ack = 1'b1;
									n.hi = r.sh[2:1];
									n.nx = ISSAM_ADDR2;
								end else if (is10 && hit && r.sh[0] && r.a10) begin
									addr_ack = 1'b1;
									n.stat.rw = 1'b1;
									n.nx = ISSAM_TX;
								end
							end else if (hit) begin
								addr_ack = 1'b1;
								n.stat.rw = r.sh[0];
								n.nx = r.sh[0] ? ISSAM_TX : ISSAM_RX;
							end
						end else if (r.st == ISSAM_ADDR2) begin
							if (hit) begin
								addr_ack = 1'b1;
								n.a10 = 1'b1;
								n.stat.rw = 1'b0;
								n.nx = ISSAM_RX;
							end
						end else if (!r.stat.receive_buffer_full_flag) begin
							// overrun leaves the held byte alone and does not ack
							rx_done = 1'b1;
							n.rx = r.sh;
							n.stat.receive_buffer_full_flag = 1'b1;
							n.sda_oe = 1'b1;
							n.st = ISSAM_ACK;
							n.nx = ISSAM_RX;
						end
						if (addr_ack) begin
							n.sda_oe = 1'b1;
							n.st = ISSAM_ACK;
						end
					end
				end
				ISSAM_ACK: begin
					if (scl_fall) begin
						n.sda_oe = 1'b0;
						n.bcnt = '0;
						n.st = r.nx;
						if (r.nx == ISSAM_TX) begin
							n.sh = r.tx;
							n.sda_oe = ~r.tx[7];
						end
					end
				end
				ISSAM_TX: begin
					if (scl_rise) begin
						n.bcnt = r.bcnt + 4'h1;
					end else if (scl_fall) begin
						if (r.bcnt == ISSAM_BYTE_BITS) begin
							n.sda_oe = 1'b0;
							tx_done = 1'b1;
							n.stat.transmit_buffer_full_flag = 1'b0;
							n.st = ISSAM_TACK;
						end else begin
							n.sh = {r.sh[6:0], 1'b0};
							n.sda_oe = ~r.sh[6];
						end
					end
				end
				ISSAM_TACK: begin
					if (scl_rise && r.sda_s) begin
						n.st = ISSAM_IDLE;
					end else if (scl_fall) begin
						n.bcnt = '0;
						n.sh = r.tx;
						n.sda_oe = ~r.tx[7];
						n.st = ISSAM_TX;
					end
				end
				ISSAM_IDLE: begin
				end
				default: begin
					n.st = ISSAM_IDLE;
				end
			endcase
		end

		// a write to the transmit holder marks it full, even at the end of a byte
		if (REG_WR && REG_ADDR == ISSAM_ADR_TXD) begin
			n.stat.transmit_buffer_full_flag = 1'b1;
		end

		ev[ISSAM_IB_ADDR] = addr_ack;
		ev[ISSAM_IB_RX] = rx_done;
		ev[ISSAM_IB_TX] = tx_done;
		n.ist = (r.ist & ~w1c) | ev;
		n.irq = |(n.ist & n.imsk);

		// read data, one cycle after the strobe
		n.rdata = '0;
		if (REG_RD) begin
			case (REG_ADDR)
				ISSAM_ADR_STATUS: n.rdata = {12'h000, r.stat};
				ISSAM_ADR_MASK:   n.rdata = {6'h00, r.mask};
				ISSAM_ADR_CTRL:   n.rdata = {14'h0000, r.ten, r.en};
				ISSAM_ADR_OWN:    n.rdata = {6'h00, r.own};
				ISSAM_ADR_RXD:    n.rdata = {8'h00, r.rx};
				ISSAM_ADR_TXD:    n.rdata = {8'h00, r.tx};
				ISSAM_ADR_IST:    n.rdata = {11'h000, r.ist};
				ISSAM_ADR_IMSK:   n.rdata = {11'h000, r.imsk};
				default:          n.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			r <= ISSAM_RST;
		end else begin
			r <= n;
		end
	end

	assign REG_RDATA = r.rdata;
	assign SDA_OUT = r.sda_o;
	assign SDA_OE = r.sda_oe;
	assign IRQ = r.irq;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);

	a_start_sets: assert property (start_det && n.en |=> r.stat.start_f)
		else $error("start flag not set after start");
	a_stop_clears: assert property (stop_det && n.en && !start_det |=> !r.stat.start_f)
		else $error("start flag not cleared after stop");
	a_disable_clears: assert property (!r.en |-> !r.stat.start_f)
		else $error("start flag set while disabled");
	a_rbf_sets: assert property (rx_done |=> r.stat.receive_buffer_full_flag && r.rx == $past(r.sh))
		else $error("receive flag or byte missing after reception");
	a_rbf_cause: assert property ($rose(r.stat.receive_buffer_full_flag) |-> $past(rx_done))
		else $error("receive flag rose without a reception");
	a_tbf_holds: assert property (r.st == ISSAM_TX && r.bcnt != ISSAM_BYTE_BITS
		&& r.stat.transmit_buffer_full_flag && r.en |=> r.stat.transmit_buffer_full_flag)
		else $error("transmit flag dropped mid byte");
	a_tbf_clears: assert property (tx_done && !(REG_WR && REG_ADDR == ISSAM_ADR_TXD)
		|=> !r.stat.transmit_buffer_full_flag)
		else $error("transmit flag not cleared after byte");
	a_mask_upper: assert property (REG_RD && REG_ADDR == ISSAM_ADR_MASK
		|=> REG_RDATA[15:10] == 6'h00 && REG_RDATA[9:0] == $past(r.mask))
		else $error("mask read back wrong");
	a_ack_needs_hit: assert property (addr_ack |-> hit ##1 (SDA_OE && r.st == ISSAM_ACK))
		else $error("address acked without match");
	a_masked_bit: assert property (r.st == ISSAM_ADDR && !r.ten && r.mask[6:0] == 7'h00
		&& r.sh[7:1] != r.own[6:0] |-> !hit)
		else $error("unmasked mismatch accepted");
	a_all_masked: assert property (!r.ten && r.mask[6:0] == 7'h7f && r.st == ISSAM_ADDR
		|-> hit)
		else $error("fully masked address missed");

	c_start: cover property (start_det && r.en);
	c_addr_ack: cover property (addr_ack);
	c_rx_byte: cover property (rx_done);
	c_tx_byte: cover property (tx_done);

endmodule : issam_top
`default_nettype wire

// file: sim/issam_mst.sv
// Purpose: behavioural two-wire bus master that drives the slave under test
// Assumes: open drain data line with pull-up, 48 ns bus clock period
// Notes:   bus clock stands high between frames; timing is free of the system clock
`timescale 1ns/1ps
`default_nettype none
module issam_mst (
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic bit_out(input logic b);
		#12 sda_pull = ~b;
		#12 scl = 1'b1;
		#24 scl = 1'b0;
	endtask : bit_out
	task automatic bit_in(output logic b);
		#12 sda_pull = 1'b0;
		#12 scl = 1'b1;
		#12 b = sda;
		#12 scl = 1'b0;
	endtask : bit_in
	task automatic start_c();
		#12 sda_pull = 1'b0;
		#12 scl = 1'b1;
		#24 sda_pull = 1'b1;
		#24 scl = 1'b0;
	endtask : start_c
	task automatic stop_c();
		#12 sda_pull = 1'b1;
		#12 scl = 1'b1;
		#24 sda_pull = 1'b0;
		#24;
	endtask : stop_c
	// msb first, acknowledge sampled in the ninth bit
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_out(b[i]);
		bit_in(a);
		ack = ~a;
	endtask : wbyte
	task automatic rbyte(output logic [7:0] d, input logic ack);
		for (int i = 7; i >= 0; i--) bit_in(d[i]);
		bit_out(~ack);
	endtask : rbyte
endmodule : issam_mst
`default_nettype wire

// file: sim/issam_tb.sv
// Purpose: self-checking bench for the two-wire slave status and mask block
// Assumes: master model runs its own bus clock, unrelated to the system clock
// Notes:   expected acks and flags come from bench functions
`timescale 1ns/1ps
`default_nettype none
module issam_tb
	import issam_pkg::*;
;
	logic        clk, reset_n, reg_wr, reg_rd, sda_out, sda_oe, irq, scl, sda_pull, sda_w, ack;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rd_v;
	logic [9:0]  own, msk, cand;
	logic [7:0]  dat, rd8;
	integer      seed = 32'h603e3e20;
	int          n_errors = 0;
	int          num_checks = 0;
	assign sda_w = ~(sda_pull | sda_oe);
	issam_top u_issam_top (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SCL_IN(scl), .SDA_IN(sda_w),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .IRQ(irq));
	issam_mst u_issam_mst (.scl(scl), .sda_pull(sda_pull), .sda(sda_w));
	initial clk = 1'b0;
	always #2 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input string what);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
		chk(rd_v, exp, what);
	endtask : rchk
	function automatic logic exp_ack(input logic [9:0] c, input logic ten);
		return ((c ^ own) & ~msk & (ten ? 10'h3ff : 10'h07f)) == 10'h000;
	endfunction : exp_ack
	function automatic logic [15:0] stat4(input logic s, input logic w, input logic r, input logic t);
		return {12'h000, s, w, r, t};
	endfunction : stat4
	task automatic xfer_w(input logic [9:0] c, input logic ten);
		logic       a;
		logic [7:0] d;
		d = 8'($random(seed));
		u_issam_mst.start_c();
		if (ten) u_issam_mst.wbyte({ISSAM_PREFIX10, c[9:8], 1'b0}, a);
		u_issam_mst.wbyte(ten ? c[7:0] : {c[6:0], 1'b0}, a);
		chk({15'h0000, a}, {15'h0000, exp_ack(c, ten)}, "address ack");
		rchk(ISSAM_ADR_STATUS, stat4(1'b1, 1'b0, 1'b0, 1'b0), "after address");
		if (a === 1'b1) begin
			u_issam_mst.wbyte(d, a);
			chk({15'h0000, a}, 16'h0001, "data ack");
			rchk(ISSAM_ADR_STATUS, stat4(1'b1, 1'b0, 1'b1, 1'b0), "rx full");
			rchk(ISSAM_ADR_RXD, {8'h00, d}, "rx byte");
			rchk(ISSAM_ADR_STATUS, stat4(1'b1, 1'b0, 1'b0, 1'b0), "rx empty");
		end
		u_issam_mst.stop_c();
		rchk(ISSAM_ADR_STATUS, 16'h0000, "after stop");
	endtask : xfer_w
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict
	initial begin
		#300000;
		n_errors++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict();
	end
	initial begin
		reset_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rchk(ISSAM_ADR_MASK, 16'h0000, "mask reset");
		rchk(ISSAM_ADR_STATUS, 16'h0000, "status reset");
		wr(ISSAM_ADR_MASK, 16'hffff);
		rchk(ISSAM_ADR_MASK, 16'h03ff, "mask width");
		wr(ISSAM_ADR_STATUS, 16'h000f);
		rchk(ISSAM_ADR_STATUS, 16'h0000, "status read only");
		wr(4'h9, 16'hffff);
		rchk(4'h9, 16'h0000, "unmapped");
		$display("test registers done");
		own = 10'($random(seed));
		msk = 10'h000;
		wr(ISSAM_ADR_OWN, {6'h00, own});
		wr(ISSAM_ADR_MASK, 16'h0000);
		u_issam_mst.start_c();
		u_issam_mst.wbyte({own[6:0], 1'b0}, ack);
		chk({15'h0000, ack}, 16'h0000, "ack while off");
		rchk(ISSAM_ADR_STATUS, 16'h0000, "start while off");
		u_issam_mst.stop_c();
		$display("test disabled done");
		wr(ISSAM_ADR_IMSK, 16'h0000);
		for (int t = 0; t < 2; t++) begin
			wr(ISSAM_ADR_CTRL, {14'h0000, t[0], 1'b1});
			for (int i = 0; i < 8; i++) begin
				msk = (i < 2) ? 10'h000 : (i == 2) ? 10'h3ff : 10'($random(seed));
				cand = (i == 1) ? own ^ 10'h001 : own ^ (msk & 10'($random(seed)));
				if (i > 4 && i[0]) cand = 10'($random(seed));
				wr(ISSAM_ADR_MASK, {6'h00, msk});
				xfer_w(cand, t[0]);
			end
		end
		$display("test address match done");
		msk = 10'h000;
		wr(ISSAM_ADR_CTRL, 16'h0001);
		wr(ISSAM_ADR_MASK, 16'h0000);
		dat = 8'($random(seed));
		// second byte while the first still waits must be refused and leave the held byte
		u_issam_mst.start_c();
		u_issam_mst.wbyte({own[6:0], 1'b0}, ack);
		u_issam_mst.wbyte(dat, ack);
		u_issam_mst.wbyte(~dat, ack);
		chk({15'h0000, ack}, 16'h0000, "overrun nack");
		rchk(ISSAM_ADR_RXD, {8'h00, dat}, "overrun keeps byte");
		u_issam_mst.stop_c();
		$display("test overrun done");
		wr(ISSAM_ADR_TXD, {8'h00, dat});
		rchk(ISSAM_ADR_STATUS, stat4(1'b0, 1'b0, 1'b0, 1'b1), "tx full");
		u_issam_mst.start_c();
		u_issam_mst.wbyte({own[6:0], 1'b1}, ack);
		chk({15'h0000, ack}, 16'h0001, "read address ack");
		rchk(ISSAM_ADR_STATUS, stat4(1'b1, 1'b1, 1'b0, 1'b1), "read direction");
		u_issam_mst.rbyte(rd8, 1'b0);
		chk({8'h00, rd8}, {8'h00, dat}, "tx byte");
		rchk(ISSAM_ADR_STATUS, stat4(1'b1, 1'b1, 1'b0, 1'b0), "tx done");
		u_issam_mst.stop_c();
		rchk(ISSAM_ADR_STATUS, stat4(1'b0, 1'b1, 1'b0, 1'b0), "after read stop");
		$display("test read done");
		u_issam_mst.start_c();
		wr(ISSAM_ADR_CTRL, 16'h0000);
		// direction keeps its last value; only the start flag is cleared by disable
		rchk(ISSAM_ADR_STATUS, stat4(1'b0, 1'b1, 1'b0, 1'b0), "disable clears");
		u_issam_mst.stop_c();
		$display("test disable done");
		chk({15'h0000, irq}, 16'h0000, "irq masked");
		chk({15'h0000, sda_out}, 16'h0000, "data out low");
		rchk(ISSAM_ADR_IST, 16'h001f, "event bits");
		wr(ISSAM_ADR_IMSK, 16'h0010);
		repeat (2) @(posedge clk);
		#1 chk({15'h0000, irq}, 16'h0001, "irq raised");
		wr(ISSAM_ADR_IST, 16'h0010);
		repeat (2) @(posedge clk);
		#1 chk({15'h0000, irq}, 16'h0000, "irq cleared");
		rchk(ISSAM_ADR_IST, 16'h000f, "one bit cleared");
		$display("test interrupt done");
		print_verdict();
	end
endmodule : issam_tb
`default_nettype wire
